/* hdl/wtp_pkg.sv */
// wtp_pkg: constants and types of the waveform trigger playback control.
// assumes one sample per ref_clk cycle.
package wtp_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int LEN_W  = 20;
    localparam int DLY_W  = 22;
    localparam int TS_W   = 32;
    localparam int CTRL_W = 10;
    localparam int ELEM_W = 8;
    localparam int MEM_AW = 4;
    localparam int CNT_W  = MEM_AW + 1;
    localparam int FRAC_W = 2;

    localparam logic [ADDR_W-1:0] OFF_CTRL  = 5'h00;
    localparam logic [ADDR_W-1:0] OFF_DELAY = 5'h04;
    localparam logic [ADDR_W-1:0] OFF_FLEN  = 5'h08;
    localparam logic [ADDR_W-1:0] OFF_GLEN  = 5'h0C;
    localparam logic [ADDR_W-1:0] OFF_DLEN  = 5'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT  = 5'h14;

    localparam int B_TRIG_EN   = 0;
    localparam int B_MODE      = 1;
    localparam int B_EDGE_FALL = 2;
    localparam int B_PAT_EN    = 3;
    localparam int B_PAT_FALL  = 4;
    localparam int B_SW_FRAME  = 5;
    localparam int B_SEQ       = 6;
    localparam int B_SELECT    = 7;
    localparam int B_HI_RATE   = 8;
    localparam int B_BURST_PAT = 9;

    localparam int S_ARMED = 0;
    localparam int S_WAIT  = 1;
    localparam int S_PLAY  = 2;
    localparam int S_GATE  = 3;
    localparam int S_PEND  = 4;
    localparam int S_CNT   = 8;
    localparam int S_ELEM  = 16;

    localparam logic [CTRL_W-1:0] CTRL_RST  = 10'h000;
    localparam logic [DLY_W-1:0]  DELAY_RST = 22'h000000;
    localparam logic [LEN_W-1:0]  FLEN_RST  = 20'h00002;
    localparam logic [LEN_W-1:0]  GLEN_RST  = 20'h00000;
    localparam logic [LEN_W-1:0]  DLEN_RST  = 20'h00002;

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_WAIT, ST_PLAY} wtp_state_t;
endpackage

/* hdl/wtp_mem_if.sv */
// wtp_mem_if: write and read port of the start time memory.
// assumes both ends run on ref_clk.
`timescale 1ns/10ps
interface wtp_mem_if;
    import wtp_pkg::*;
    logic              wr_en;
    logic [MEM_AW-1:0] wr_addr;
    logic [TS_W-1:0]   wr_data;
    logic [MEM_AW-1:0] rd_addr;
    logic [TS_W-1:0]   rd_data;
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
    modport user (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
endinterface

/* hdl/wtp_stamp_mem.sv */
// wtp_stamp_mem: small memory of scheduled start times, registered read.
// assumes the user reads a word only one cycle after its address settles.
`timescale 1ns/10ps
module wtp_stamp_mem
(
    input wire logic ref_clk,
    wtp_mem_if.mem   port
);
    import wtp_pkg::*;

    logic [TS_W-1:0] mem_r [2**MEM_AW];
    logic [TS_W-1:0] rd_r;

    // no reset: words are read only after being written
    always_ff @(posedge ref_clk)
    begin
        if (port.wr_en)
            mem_r[port.wr_addr] <= port.wr_data;
        rd_r <= mem_r[port.rd_addr];
    end

    assign port.rd_data = rd_r;
endmodule

/* hdl/wtp_trig_edge.sv */
// wtp_trig_edge: pin synchroniser and active edge pulse.
// assumes trig_pin is asynchronous to ref_clk.
`timescale 1ns/10ps
module wtp_trig_edge
(
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic trig_pin,
    input  wire logic fall_sel,
    output logic      pulse
);
    logic s1_r, s2_r, s3_r, pulse_r;
    logic pulse_nxt;

    // s1_r feeds s2_r only
    always_comb
    begin
        pulse_nxt = fall_sel ? (s3_r & ~s2_r) : (~s3_r & s2_r);
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_r    <= 1'b0;
            s2_r    <= 1'b0;
            s3_r    <= 1'b0;
            pulse_r <= 1'b0;
        end
        else
        begin
            s1_r    <= trig_pin;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            pulse_r <= pulse_nxt;
        end
    end

    assign pulse = pulse_r;
endmodule

/* hdl/wtp_trigger_ctrl.sv */
// wtp_trigger_ctrl: external trigger control of waveform pattern playback.
// assumes one sample per ref_clk, Avalon-MM master on the same clock.
// Function
// - two trigger kinds: start position, or timing of each burst.
// - active edge of the trigger input selectable rising or falling.
// - start mode begins output on first active edge after pattern select.
// - start mode ignores later edges while the pattern keeps playing.
// - delay zero starts output one frame period after trigger; delay adds samples.
// - frame period is frame length plus gap length.
// - continuous patterns have zero gap.
// - burst patterns: frame is slot samples, gap is remainder or zero.
// - burst mode outputs exactly one burst per accepted edge.
// - burst mode delay follows the start mode delay.
// - burst mode masks edges closer than a frame period to the last.
// - sequence mode advances element on switch trigger edge.
// - data-end switching only at multiples of element data length.
// - frame-end switching only at element frame boundaries.
// - delay set in samples, quarter sample below high rate, else whole.
// - mode or delay change restarts and re-arms for a fresh trigger.
// - triggers and their settings act only while enabled; a mode or delay change still restarts free run while disabled.
`timescale 1ns/10ps
module wtp_trigger_ctrl
(
    input  wire logic                      ref_clk,
    input  wire logic                      arst_n,
    input  wire logic [wtp_pkg::ADDR_W-1:0] avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [wtp_pkg::DATA_W-1:0] avs_writedata,
    output logic      [wtp_pkg::DATA_W-1:0] avs_readdata,
    output logic                           avs_waitrequest,
    input  wire logic                      playback_trigger,
    input  wire logic                      element_switch_trigger,
    output logic                           stream_start,
    output logic                           burst_gate,
    output logic                           playing,
    output logic                           element_advance,
    output logic      [wtp_pkg::FRAC_W-1:0] delay_frac
);
    import wtp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    logic                ack_r, ack_nxt;
    logic [DATA_W-1:0]   rdata_r, rdata_nxt;
    logic [CTRL_W-1:0]   ctrl_r, ctrl_nxt;
    logic [DLY_W-1:0]    delay_r, delay_nxt;
    logic [LEN_W-1:0]    flen_r, flen_nxt;
    logic [LEN_W-1:0]    glen_r, glen_nxt;
    logic [LEN_W-1:0]    dlen_r, dlen_nxt;
    logic                wr_go;
    logic                rearm;

    wtp_state_t          state_r, state_nxt;
    logic [TS_W-1:0]     now_r;
    logic [TS_W-1:0]     since_r, since_nxt;
    logic [MEM_AW-1:0]   wr_ptr_r, wr_ptr_nxt;
    logic [MEM_AW-1:0]   rd_ptr_r, rd_ptr_nxt;
    logic [CNT_W-1:0]    cnt_r, cnt_nxt;
    logic                stale_r, stale_nxt;
    logic [LEN_W-1:0]    bcnt_r, bcnt_nxt;
    logic                start_r, start_nxt;
    logic                gate_r, gate_nxt;
    logic                play_r, play_nxt;
    logic [FRAC_W-1:0]   frac_r, frac_nxt;
    logic [TS_W-1:0]     pos_r, pos_nxt;
    logic                pend_r, pend_nxt;
    logic                adv_r, adv_nxt;
    logic [ELEM_W-1:0]   elem_r, elem_nxt;
    logic [TS_W-1:0]     wait_r;

    logic [1:0]          pins, fall, pulse;
    logic                trig_en, mode_burst, seq_ok;
    logic [TS_W-1:0]     per, dtot, unit, pos_inc, head_diff;
    logic                acc_start, acc_burst, push, due, pop, running, bound, adv, pat_ok;

    wtp_mem_if mif();

    wtp_stamp_mem u_mem
    (
        .ref_clk (ref_clk),
        .port    (mif)
    );

    ////////////////////////////////////////////////////////////////////////////
    // trigger pins
    assign pins = {element_switch_trigger, playback_trigger};
    assign fall = {ctrl_r[B_PAT_FALL], ctrl_r[B_EDGE_FALL]};

    for (genvar g = 0; g < 2; g++)
    begin : g_trig
        wtp_trig_edge u_edge
        (
            .ref_clk  (ref_clk),
            .arst_n   (arst_n),
            .trig_pin (pins[g]),
            .fall_sel (fall[g]),
            .pulse    (pulse[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // register bus: every access answers one cycle after it is raised
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata    = rdata_r;
    assign wr_go           = avs_write & ack_r;
    assign rearm = wr_go & (((avs_address == OFF_CTRL) & (avs_writedata[B_SELECT]
                   | (avs_writedata[B_MODE] != ctrl_r[B_MODE])
                   | (avs_writedata[B_TRIG_EN] != ctrl_r[B_TRIG_EN])))
                   | (avs_address == OFF_DELAY));

    always_comb
    begin
        ack_nxt   = (avs_read | avs_write) & ~ack_r;
        rdata_nxt = rdata_r;
        ctrl_nxt  = ctrl_r;
        delay_nxt = delay_r;
        flen_nxt  = flen_r;
        glen_nxt  = glen_r;
        dlen_nxt  = dlen_r;
        if (wr_go)
        begin
            unique case (avs_address)
                OFF_CTRL:  ctrl_nxt  = avs_writedata[CTRL_W-1:0] & ~(10'h001 << B_SELECT);
                OFF_DELAY: delay_nxt = avs_writedata[DLY_W-1:0];
                OFF_FLEN:  flen_nxt  = avs_writedata[LEN_W-1:0];
                OFF_GLEN:  glen_nxt  = avs_writedata[LEN_W-1:0];
                OFF_DLEN:  dlen_nxt  = avs_writedata[LEN_W-1:0];
                default:   ;
            endcase
        end
        if (avs_read & ack_nxt)
        begin
            unique case (avs_address)
                OFF_CTRL:  rdata_nxt = DATA_W'(ctrl_r);
                OFF_DELAY: rdata_nxt = DATA_W'(delay_r);
                OFF_FLEN:  rdata_nxt = DATA_W'(flen_r);
                OFF_GLEN:  rdata_nxt = DATA_W'(glen_r);
                OFF_DLEN:  rdata_nxt = DATA_W'(dlen_r);
                OFF_STAT:
                begin
                    rdata_nxt           = 32'h00000000;
                    rdata_nxt[S_ARMED]  = (state_r == ST_ARMED);
                    rdata_nxt[S_WAIT]   = (state_r == ST_WAIT);
                    rdata_nxt[S_PLAY]   = play_r;
                    rdata_nxt[S_GATE]   = gate_r;
                    rdata_nxt[S_PEND]   = pend_r;
                    rdata_nxt[S_CNT +: CNT_W]   = cnt_r;
                    rdata_nxt[S_ELEM +: ELEM_W] = elem_r;
                end
                default:   rdata_nxt = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 32'h00000000;
            ctrl_r  <= CTRL_RST;
            delay_r <= DELAY_RST;
            flen_r  <= FLEN_RST;
            glen_r  <= GLEN_RST;
            dlen_r  <= DLEN_RST;
        end
        else
        begin
            ack_r   <= ack_nxt;
            rdata_r <= rdata_nxt;
            ctrl_r  <= ctrl_nxt;
            delay_r <= delay_nxt;
            flen_r  <= flen_nxt;
            glen_r  <= glen_nxt;
            dlen_r  <= dlen_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger scheduling
    assign trig_en    = ctrl_r[B_TRIG_EN];
    assign mode_burst = ctrl_r[B_MODE];
    // continuous patterns carry no gap
    assign per  = TS_W'(flen_r) + (ctrl_r[B_BURST_PAT] ? TS_W'(glen_r) : 32'h00000000);
    assign dtot = per + TS_W'(delay_r[DLY_W-1:FRAC_W]);

    assign acc_start = pulse[0] & trig_en & ~mode_burst & (state_r == ST_ARMED);
    // a full memory also masks, so no scheduled burst is ever lost
    assign acc_burst = pulse[0] & trig_en & mode_burst & (state_r == ST_ARMED)
                       & (since_r >= per) & ~cnt_r[MEM_AW];
    assign push      = (acc_start | acc_burst) & ~rearm;
    assign head_diff = now_r - mif.rd_data;
    assign due       = (cnt_r != 5'h00) & ~stale_r & ~head_diff[TS_W-1];
    assign pop       = due & ~rearm;

    assign mif.wr_en   = push;
    assign mif.wr_addr = wr_ptr_r;
    assign mif.wr_data = now_r + dtot;
    assign mif.rd_addr = rd_ptr_r;

    // element switching
    assign seq_ok  = ctrl_r[B_PAT_EN] & ctrl_r[B_SEQ];
    assign pat_ok  = pulse[1] & seq_ok;
    assign running = (state_r == ST_PLAY) | gate_r;
    assign unit    = ctrl_r[B_SW_FRAME] ? per : TS_W'(dlen_r);
    assign pos_inc = pos_r + 32'h00000001;
    assign bound   = running & (pos_inc >= unit);
    assign adv     = bound & pend_r & seq_ok;

    always_comb
    begin
        state_nxt  = state_r;
        since_nxt  = (&since_r) ? since_r : since_r + 32'h00000001;
        wr_ptr_nxt = wr_ptr_r + MEM_AW'(push);
        rd_ptr_nxt = rd_ptr_r + MEM_AW'(pop);
        cnt_nxt    = cnt_r + CNT_W'(push) - CNT_W'(pop);
        stale_nxt  = pop | (push & (cnt_r == 5'h00));
        bcnt_nxt   = (bcnt_r != 20'h00000) ? bcnt_r - 20'h00001 : bcnt_r;
        start_nxt  = 1'b0;
        frac_nxt   = ctrl_r[B_HI_RATE] ? 2'h0 : delay_r[FRAC_W-1:0];
        pos_nxt    = running ? (bound ? 32'h00000000 : pos_inc) : pos_r;
        // a switch edge on the advance cycle stays pending
        pend_nxt   = pat_ok | (pend_r & ~adv & ~rearm);
        adv_nxt    = adv;
        elem_nxt   = elem_r + ELEM_W'(adv);
        if (acc_burst & ~rearm)
            since_nxt = 32'h00000001;
        if (pop)
        begin
            start_nxt = 1'b1;
            if (mode_burst)
                bcnt_nxt = flen_r;
        end
        unique case (state_r)
            ST_IDLE:  ;
            ST_ARMED: if (acc_start) state_nxt = ST_WAIT;
            ST_WAIT:  if (due) state_nxt = ST_PLAY;
            ST_PLAY:  ;
        endcase
        if (rearm)
        begin
            // disabled trigger: free run from the select
            state_nxt  = ctrl_nxt[B_TRIG_EN] ? ST_ARMED : ST_PLAY;
            start_nxt  = ~ctrl_nxt[B_TRIG_EN];
            since_nxt  = 32'hFFFFFFFF;
            wr_ptr_nxt = 4'h0;
            rd_ptr_nxt = 4'h0;
            cnt_nxt    = 5'h00;
            bcnt_nxt   = 20'h00000;
            pos_nxt    = 32'h00000000;
        end
        gate_nxt = (bcnt_nxt != 20'h00000);
        play_nxt = (state_nxt == ST_PLAY) | gate_nxt;
    end

    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r  <= ST_IDLE;
            now_r    <= 32'h00000000;
            since_r  <= 32'hFFFFFFFF;
            wr_ptr_r <= 4'h0;
            rd_ptr_r <= 4'h0;
            cnt_r    <= 5'h00;
            stale_r  <= 1'b0;
            bcnt_r   <= 20'h00000;
            start_r  <= 1'b0;
            gate_r   <= 1'b0;
            play_r   <= 1'b0;
            frac_r   <= 2'h0;
            pos_r    <= 32'h00000000;
            pend_r   <= 1'b0;
            adv_r    <= 1'b0;
            elem_r   <= 8'h00;
            wait_r   <= 32'h00000000;
        end
        else
        begin
            state_r  <= state_nxt;
            now_r    <= now_r + 32'h00000001;
            since_r  <= since_nxt;
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            cnt_r    <= cnt_nxt;
            stale_r  <= stale_nxt;
            bcnt_r   <= bcnt_nxt;
            start_r  <= start_nxt;
            gate_r   <= gate_nxt;
            play_r   <= play_nxt;
            frac_r   <= frac_nxt;
            pos_r    <= pos_nxt;
            pend_r   <= pend_nxt;
            adv_r    <= adv_nxt;
            elem_r   <= elem_nxt;
            wait_r   <= (state_r == ST_WAIT) ? wait_r + 32'h00000001 : 32'h00000000;
        end
    end

    assign stream_start    = start_r;
    assign burst_gate      = gate_r;
    assign playing         = play_r;
    assign element_advance = adv_r;
    assign delay_frac      = frac_r;

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_start_due;
        (state_r == ST_WAIT) && due && !rearm;
    endsequence
    sequence s_burst_due;
        pop && mode_burst;
    endsequence

    property p_rearm;
        rearm |=> (cnt_r == 5'h00) && (state_r == (trig_en ? ST_ARMED : ST_PLAY));
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearm did not flush");

    property p_ignore;
        (state_r == ST_PLAY) && !mode_burst && pulse[0] && !rearm |-> !push;
    endproperty
    a_ignore: assert property (p_ignore) else $error("later edge accepted");

    property p_delay;
        s_start_due |-> (dtot < 32'h00000002) || (wait_r == dtot - 32'h00000001);
    endproperty
    a_delay: assert property (p_delay) else $error("start delay wrong");

    property p_start;
        s_start_due |=> stream_start && playing && (state_r == ST_PLAY);
    endproperty
    a_start: assert property (p_start) else $error("start missing");

    property p_burst;
        s_burst_due ##1 !rearm |-> burst_gate && (bcnt_r == flen_r);
    endproperty
    a_burst: assert property (p_burst) else $error("burst length wrong");

    property p_mask;
        pulse[0] && mode_burst && trig_en && (since_r < per) |-> !push;
    endproperty
    a_mask: assert property (p_mask) else $error("early edge not masked");

    property p_enable;
        !trig_en |-> !push;
    endproperty
    a_enable: assert property (p_enable) else $error("disabled trigger acted");

    property p_adv;
        element_advance |-> $past(pend_r) && (pos_r == 32'h00000000) && $past(bound);
    endproperty
    a_adv: assert property (p_adv) else $error("advance off boundary");

    property p_seq_off;
        !seq_ok |=> !element_advance;
    endproperty
    a_seq_off: assert property (p_seq_off) else $error("advance while disabled");

    property p_pulse;
        pulse[0] |=> !pulse[0];
    endproperty
    a_pulse: assert property (p_pulse) else $error("edge pulse too long");
endmodule

/* tb/wtp_trig_src.sv */
// wtp_trig_src: outside system that drives one trigger pin.
// assumes the bench calls its tasks; edges land just after ref_clk rises.
`timescale 1ns/10ps
module wtp_trig_src
(
    input  wire logic ref_clk,
    output logic      pin
);
    initial pin = 1'b0;

    task automatic set(input logic v);
        @(posedge ref_clk);
        pin <= v;
    endtask

    // high and low each held 10 cycles, the 40 ns minimum; edges 20 apart
    task automatic pulse;
        set(1'b1);
        repeat (9) @(posedge ref_clk);
        set(1'b0);
        repeat (9) @(posedge ref_clk);
    endtask
endmodule

/* tb/test_waveform_trigger_playback_ctrl.sv */
// test_waveform_trigger_playback_ctrl: self-checking bench of wtp_trigger_ctrl.
// assumes one sample per ref_clk and the register map of wtp_pkg.
`timescale 1ns/10ps
module test_waveform_trigger_playback_ctrl;
    import wtp_pkg::*;
    logic                ref_clk = 1'b0;
    logic                arst_n = 1'b0;
    logic [ADDR_W-1:0]   avs_address;
    logic                avs_read;
    logic                avs_write;
    logic [DATA_W-1:0]   avs_writedata;
    logic [DATA_W-1:0]   avs_readdata;
    logic                avs_waitrequest;
    logic                trig_play;
    logic                trig_sw;
    logic                stream_start;
    logic                burst_gate;
    logic                playing;
    logic                element_advance;
    logic [FRAC_W-1:0]   delay_frac;
    int                  n_fail = 0;
    int                  n_tests = 0;
    int                  ss_c = 0;
    int                  gt_c = 0;
    int                  ad_c = 0;
    time                 ad_t = 0;

    always #2 ref_clk = ~ref_clk;

    wtp_trigger_ctrl u_wtp_trigger_ctrl (.ref_clk(ref_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .playback_trigger(trig_play),
        .element_switch_trigger(trig_sw), .stream_start(stream_start),
        .burst_gate(burst_gate), .playing(playing), .element_advance(element_advance),
        .delay_frac(delay_frac));
    wtp_trig_src u_src_play (.ref_clk(ref_clk), .pin(trig_play));
    wtp_trig_src u_src_sw (.ref_clk(ref_clk), .pin(trig_sw));

    // outputs are registered, so sampling on the edge sees the settled value
    always @(posedge ref_clk)
    begin
        ss_c += (stream_start === 1'b1);
        gt_c += (burst_gate === 1'b1);
        ad_c += (element_advance === 1'b1);
        if (element_advance === 1'b1)
            ad_t = $time;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        for (i = 0; i < 50; i++)
        begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0)
                break;
        end
        if (i == 50)
        begin
            n_fail++;
            wrap_up();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] q);
        bus(1'b0, a, 32'h0, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // edges from the trigger pin change up to the stream start being seen
    task automatic wait_start(output int n);
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (stream_start !== 1'b1 && n < 200);
        if (n >= 200)
        begin
            n_fail++;
            wrap_up();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        logic [31:0] q;
        rd(OFF_CTRL, q);
        chk(q, 32'h0, "ctrl reset");
        rd(OFF_DELAY, q);
        chk(q, 32'h0, "delay reset");
        rd(OFF_FLEN, q);
        chk(q, 32'h2, "flen reset");
        rd(OFF_GLEN, q);
        chk(q, 32'h0, "glen reset");
        rd(OFF_DLEN, q);
        chk(q, 32'h2, "dlen reset");
        wr(5'h18, 32'hFFFF_FFFF);
        rd(5'h18, q);
        chk(q, 32'h0, "unmapped read");
    endtask

    // gap written but ignored: continuous pattern, D = 3 + 2
    task automatic t_start;
        int n;
        int s;
        wr(OFF_FLEN, 32'h3);
        wr(OFF_GLEN, 32'h7);
        wr(OFF_DELAY, 32'h8);
        wr(OFF_CTRL, 32'h081);
        idle(3);
        u_src_play.set(1'b1);
        wait_start(n);
        chk(n, 10, "start delay");
        idle(2);
        chk(playing, 1'b1, "playing");
        s = ss_c;
        u_src_play.set(1'b0);
        idle(10);
        u_src_play.pulse();
        idle(20);
        chk(ss_c - s, 0, "second edge ignored");
    endtask

    task automatic t_rearm_fall;
        int n;
        int s;
        logic [31:0] q;
        wr(OFF_DELAY, 32'hB);
        idle(2);
        chk(playing, 1'b0, "delay write stops");
        chk(delay_frac, 2'h3, "quarter part");
        rd(OFF_STAT, q);
        chk(q[S_ARMED], 1'b1, "re-armed");
        rd(OFF_DELAY, q);
        chk(q, 32'hB, "delay readback");
        wr(OFF_CTRL, 32'h085);
        rd(OFF_CTRL, q);
        chk(q, 32'h5, "select reads zero");
        idle(3);
        s = ss_c;
        u_src_play.set(1'b1);
        idle(15);
        chk(ss_c - s, 0, "rise ignored in fall mode");
        u_src_play.set(1'b0);
        wait_start(n);
        chk(n, 10, "fall edge start");
        u_src_play.set(1'b0);
    endtask

    // period 24, D = 24; edges 20 apart fall inside the period
    task automatic t_burst;
        int n;
        int s;
        int g;
        wr(OFF_FLEN, 32'h10);
        wr(OFF_GLEN, 32'h8);
        wr(OFF_DELAY, 32'h3);
        wr(OFF_CTRL, 32'h383);
        idle(3);
        chk(delay_frac, 2'h0, "whole samples at high rate");
        u_src_play.set(1'b1);
        wait_start(n);
        chk(n, 29, "burst delay");
        u_src_play.set(1'b0);
        idle(25);
        s = ss_c;
        g = gt_c;
        u_src_play.pulse();
        u_src_play.pulse();
        u_src_play.pulse();
        idle(40);
        chk(ss_c - s, 2, "bursts with one masked");
        chk(gt_c - g, 32, "gate length");
        // period 20: edges exactly one period apart are all taken
        wr(OFF_GLEN, 32'h4);
        s = ss_c;
        u_src_play.pulse();
        u_src_play.pulse();
        idle(40);
        chk(ss_c - s, 2, "edges one period apart");
    endtask

    task automatic t_disabled;
        int n;
        int s;
        wr(OFF_CTRL, 32'h080);
        wait_start(n);
        idle(1);
        chk(playing, 1'b1, "free run");
        s = ss_c;
        u_src_play.pulse();
        idle(20);
        chk(ss_c - s, 0, "disabled trigger ignored");
    endtask

    // advance seen one cycle after the boundary cycle, counted from the select
    task automatic t_seq;
        int a;
        time t0;
        wr(OFF_DLEN, 32'h4);
        wr(OFF_CTRL, 32'h0C8);
        t0 = $time;
        idle(5);
        a = ad_c;
        u_src_sw.pulse();
        idle(20);
        chk(ad_c - a, 1, "data end advance");
        chk(32'((ad_t - t0) / 4 % 4), 1, "data end boundary");
        // frame end, falling switch edge; frame 16, gap unused
        wr(OFF_CTRL, 32'h0F8);
        t0 = $time;
        idle(5);
        a = ad_c;
        u_src_sw.pulse();
        idle(20);
        chk(ad_c - a, 1, "frame end advance");
        chk(32'((ad_t - t0) / 4 % 16), 1, "frame end boundary");
        wr(OFF_CTRL, 32'h0C0);
        idle(5);
        a = ad_c;
        u_src_sw.pulse();
        idle(20);
        chk(ad_c - a, 0, "switch disabled");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        avs_address <= 5'h00;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        avs_writedata <= 32'h00000000;
        repeat (20) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_regs();
        t_start();
        t_rearm_fall();
        t_burst();
        t_disabled();
        t_seq();
        wrap_up();
    end
endmodule
